// ==== design/vbr_engine.sv ====
// block request engine with apb register port and backing store
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "vbr_regs.svh"
module vbr_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ==========================================================
  // state
  vbr_pkg::vbr_state_type st_q, st_d;
  logic [7:0] feat_q, feat_d, res_q, res_d, stat_q, stat_d, sense_q, sense_d;
  logic wb_q, wb_d, used_q, used_d, isrd_q, isrd_d, flush_q, flush_d, wbseen_q, wbseen_d;
  logic [31:0] type_q, type_d, slo_q, slo_d, shi_q, shi_d, len_q, len_d, nsec_q, nsec_d;
  logic [31:0] flags_q, flags_d, cmdlen_q, cmdlen_d, resid_q, resid_d, dirty_q, dirty_d;
  logic [9:0] idx_q, idx_d, idx_end_q, idx_end_d;
  logic [7:0] cnt_q, cnt_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d, rmux;
  logic mem_we;
  logic [`MEM_AW-1:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata;

  function automatic logic [31:0] swap32(input logic [31:0] v);
    swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  // ==========================================================
  // header decode
  logic swap, acc, start, mapped, stable, wr_ok;
  logic [31:0] htype, code;
  logic [63:0] sec;
  logic [64:0] end_rw, end_wz;
  assign swap = feat_q[`FEAT_LEGACY] & feat_q[`FEAT_GUEST_BE];
  assign htype = swap ? swap32(type_q) : type_q;
  assign sec = swap ? {swap32(slo_q), swap32(shi_q)} : {shi_q, slo_q};
  // barrier strips its bit; one request in flight orders everything around it
  assign code = feat_q[`FEAT_BARRIER] ? {1'b0, htype[30:0]} : htype;
  assign end_rw = {1'b0, sec} + {42'h0, len_q[31:`SECTOR_SHIFT]};
  assign end_wz = {1'b0, sec} + {33'h0, nsec_q};
  assign acc = psel & penable & pready_q;
  assign start = acc & pwrite & (paddr == `OFF_DOORBELL) & pwdata[0] & (st_q == vbr_pkg::IDLE_S);
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `OFF_DIRTY);
  // commit before completion also when flush is not offered: no silent loss
  assign stable = !feat_q[`FEAT_FLUSH_OFF]
    | (!feat_q[`FEAT_FLUSH_NEG] & !feat_q[`FEAT_WCE_NEG])
    | (feat_q[`FEAT_WCE_NEG] & !wbseen_q);
  assign wr_ok = !feat_q[`FEAT_RO];

  // ==========================================================
  // backing store port
  assign mem_we = ((st_q == vbr_pkg::XFER_S) & !isrd_q & acc & pwrite & (paddr == `OFF_DATA) & wr_ok)
    | ((st_q == vbr_pkg::ZERO_S) & (idx_q != idx_end_q) & wr_ok);
  assign mem_addr = {sec[1:0], 7'h00} + idx_q[`MEM_AW-1:0];
  assign mem_wdata = (st_q == vbr_pkg::ZERO_S) ? 32'h00000000 : pwdata;

  vbr_mem #(.AW(`MEM_AW), .DW(32)) u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // apb response: one wait state for every access
  always_comb
  begin
    rmux = 32'h00000000;
    case (paddr)
      `OFF_FEAT: rmux = {24'h0, feat_q};
      `OFF_WBACK: rmux = {31'h0, wb_q};
      `OFF_MAYUNMAP: rmux = 32'h00000000;
      `OFF_TYPE: rmux = type_q;
      `OFF_SEC_LO: rmux = slo_q;
      `OFF_SEC_HI: rmux = shi_q;
      `OFF_LEN: rmux = len_q;
      `OFF_NSEC: rmux = nsec_q;
      `OFF_FLAGS: rmux = flags_q;
      `OFF_CMDLEN: rmux = cmdlen_q;
      `OFF_STATUS: rmux = {21'h0, (st_q == vbr_pkg::XFER_S), (st_q != vbr_pkg::IDLE_S), used_q, stat_q};
      `OFF_DATA: rmux = ((st_q == vbr_pkg::XFER_S) & isrd_q) ? mem_rdata : 32'h00000000;
      `OFF_SENSE: rmux = {24'h0, sense_q};
      `OFF_RESID: rmux = resid_q;
      `OFF_DIRTY: rmux = dirty_q;
      default: rmux = 32'h00000000;
    endcase
    pready_d = psel & penable & !pready_q;
    pslverr_d = pready_d & !mapped;
    prdata_d = (pready_d & !pwrite) ? rmux : 32'h00000000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ==========================================================
  // registers and request sequencer
  always_comb
  begin
    st_d = st_q;
    feat_d = feat_q;
    wb_d = wb_q;
    type_d = type_q;
    slo_d = slo_q;
    shi_d = shi_q;
    len_d = len_q;
    nsec_d = nsec_q;
    flags_d = flags_q;
    cmdlen_d = cmdlen_q;
    res_d = res_q;
    stat_d = stat_q;
    used_d = used_q;
    sense_d = sense_q;
    resid_d = resid_q;
    dirty_d = dirty_q;
    idx_d = idx_q;
    idx_end_d = idx_end_q;
    cnt_d = cnt_q;
    isrd_d = isrd_q;
    flush_d = flush_q;
    wbseen_d = wbseen_q | wb_q;
    // header registers only change while idle, so a request cannot be edited mid-flight
    if (acc & pwrite & (st_q == vbr_pkg::IDLE_S))
    begin
      case (paddr)
        `OFF_FEAT: feat_d = pwdata[7:0];
        `OFF_TYPE: type_d = pwdata;
        `OFF_SEC_LO: slo_d = pwdata;
        `OFF_SEC_HI: shi_d = pwdata;
        `OFF_LEN: len_d = pwdata;
        `OFF_NSEC: nsec_d = pwdata;
        `OFF_FLAGS: flags_d = pwdata;
        `OFF_CMDLEN: cmdlen_d = pwdata;
        default: ;
      endcase
    end
    if (acc & pwrite & (paddr == `OFF_WBACK) & feat_q[`FEAT_WCE_NEG])
    begin
      wb_d = pwdata[0];
    end
    case (st_q)
      vbr_pkg::IDLE_S:
      begin
        if (start)
        begin
          st_d = vbr_pkg::DECODE_S;
          used_d = 1'b0;
          idx_d = 10'h000;
          cnt_d = 8'h00;
          flush_d = 1'b0;
          wbseen_d = wb_q;
        end
      end
      vbr_pkg::DECODE_S:
      begin
        st_d = vbr_pkg::DONE_S;
        res_d = `S_UNSUPP;
        if ((code == `T_IN) || (code == `T_OUT))
        begin
          isrd_d = (code == `T_IN);
          idx_end_d = len_q[11:2];
          if ((len_q[`SECTOR_SHIFT-1:0] != 9'h000) || (end_rw > `CAP_SECTORS))
          begin
            res_d = `S_IOERR;
          end
          else if ((code == `T_OUT) && !wr_ok)
          begin
            res_d = `S_IOERR;
          end
          else if (len_q == 32'h00000000)
          begin
            res_d = `S_OK;
          end
          else
          begin
            st_d = vbr_pkg::XFER_S;
          end
        end
        else if ((code == `T_FLUSH) || ((code == `T_FLUSH_OUT) && feat_q[`FEAT_LEGACY]))
        begin
          res_d = `S_OK;
          flush_d = 1'b1;
          if (dirty_q != 32'h00000000)
          begin
            st_d = vbr_pkg::COMMIT_S;
          end
        end
        else if ((code == `T_DISCARD) || (code == `T_WZEROES))
        begin
          isrd_d = 1'b0;
          idx_end_d = {nsec_q[2:0], 7'h00};
          if (flags_q[31:1] != 31'h0)
          begin
            res_d = `S_UNSUPP;
          end
          else if (code == `T_DISCARD)
          begin
            // nothing is deallocated, so stored data simply stays
            res_d = flags_q[0] ? `S_UNSUPP : `S_OK;
          end
          else if (!wr_ok || (end_wz > `CAP_SECTORS))
          begin
            res_d = `S_IOERR;
          end
          else if (nsec_q == 32'h00000000)
          begin
            res_d = `S_OK;
          end
          else
          begin
            st_d = vbr_pkg::ZERO_S;
          end
        end
        else if (((code == `T_SCSI) || (code == `T_SCSI_OUT)) && feat_q[`FEAT_SCSI])
        begin
          // no packet target behind the store: nothing moved, no sense bytes
          res_d = (cmdlen_q == 32'h00000000) ? `S_IOERR : `S_UNSUPP;
          sense_d = 8'h00;
          resid_d = len_q;
        end
      end
      vbr_pkg::XFER_S, vbr_pkg::ZERO_S:
      begin
        if ((st_q == vbr_pkg::ZERO_S) || (acc & (paddr == `OFF_DATA) & (pwrite != isrd_q)))
        begin
          idx_d = idx_q + 10'h001;
        end
        if (idx_q == idx_end_q)
        begin
          res_d = `S_OK;
          st_d = vbr_pkg::DONE_S;
          if (!isrd_q && stable)
          begin
            st_d = vbr_pkg::COMMIT_S;
          end
          else if (!isrd_q)
          begin
            dirty_d = dirty_q + {29'h0, idx_end_q[9:`WORD_SHIFT]};
          end
          idx_d = idx_q;
        end
      end
      vbr_pkg::COMMIT_S:
      begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == 8'(`COMMIT_CYC - 1))
        begin
          st_d = vbr_pkg::DONE_S;
          if (flush_q)
          begin
            dirty_d = 32'h00000000;
          end
        end
      end
      vbr_pkg::DONE_S:
      begin
        stat_d = res_q;
        st_d = vbr_pkg::USED_S;
      end
      vbr_pkg::USED_S:
      begin
        used_d = 1'b1;
        st_d = vbr_pkg::IDLE_S;
      end
      default: st_d = vbr_pkg::IDLE_S;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= vbr_pkg::IDLE_S;
      feat_q <= `FEAT_RESET;
      wb_q <= 1'b0;
      type_q <= 32'h00000000;
      slo_q <= 32'h00000000;
      shi_q <= 32'h00000000;
      len_q <= 32'h00000000;
      nsec_q <= 32'h00000000;
      flags_q <= 32'h00000000;
      cmdlen_q <= 32'h00000000;
      res_q <= 8'h00;
      stat_q <= 8'h00;
      used_q <= 1'b0;
      sense_q <= 8'h00;
      resid_q <= 32'h00000000;
      dirty_q <= 32'h00000000;
      idx_q <= 10'h000;
      idx_end_q <= 10'h000;
      cnt_q <= 8'h00;
      isrd_q <= 1'b0;
      flush_q <= 1'b0;
      wbseen_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      feat_q <= feat_d;
      wb_q <= wb_d;
      type_q <= type_d;
      slo_q <= slo_d;
      shi_q <= shi_d;
      len_q <= len_d;
      nsec_q <= nsec_d;
      flags_q <= flags_d;
      cmdlen_q <= cmdlen_d;
      res_q <= res_d;
      stat_q <= stat_d;
      used_q <= used_d;
      sense_q <= sense_d;
      resid_q <= resid_d;
      dirty_q <= dirty_d;
      idx_q <= idx_d;
      idx_end_q <= idx_end_d;
      cnt_q <= cnt_d;
      isrd_q <= isrd_d;
      flush_q <= flush_d;
      wbseen_q <= wbseen_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_decode;
    st_q == vbr_pkg::DECODE_S;
  endsequence
  sequence s_report(logic [7:0] s);
    ##2 (stat_q == s) ##1 used_q;
  endsequence
  a_ro_no_store: assert property (feat_q[`FEAT_RO] |-> !mem_we) else $error("store written while read-only");
  a_ro_write_err: assert property (s_decode and (code == `T_OUT) && !wr_ok |-> s_report(`S_IOERR))
    else $error("read-only write not failed");
  a_flag_unsupp: assert property (s_decode and (code == `T_WZEROES) && (flags_q[31:1] != 31'h0)
    |-> s_report(`S_UNSUPP)) else $error("unknown flag accepted");
  a_disc_unmap: assert property (s_decode and (code == `T_DISCARD) && (flags_q == 32'h00000001)
    |-> s_report(`S_UNSUPP)) else $error("discard with unmap accepted");
  a_zero_fill: assert property ((st_q == vbr_pkg::ZERO_S) && wr_ok && (idx_q != idx_end_q)
    |-> mem_we && (mem_wdata == 32'h00000000)) else $error("write-zeroes stored nonzero");
  a_zero_bound: assert property ((st_q == vbr_pkg::ZERO_S) && (idx_q == idx_end_q) |-> !mem_we)
    else $error("write-zeroes ran past its range");
  a_unmap_field: assert property (pready_d && !pwrite && (paddr == `OFF_MAYUNMAP)
    |=> (prdata_q == 32'h00000000)) else $error("may-unmap field not clear");
  a_commit_wait: assert property ((st_q == vbr_pkg::COMMIT_S) && (cnt_q != 8'(`COMMIT_CYC - 1))
    |=> (st_q == vbr_pkg::COMMIT_S) && (cnt_q == $past(cnt_q) + 8'h01)) else $error("commit cut short");
  a_flush_clean: assert property ((st_q == vbr_pkg::DONE_S) && flush_q |-> (dirty_q == 32'h00000000))
    else $error("flush reported with dirty data");
  a_flush_alias: assert property (s_decode and feat_q[`FEAT_LEGACY] && (code == `T_FLUSH_OUT)
    && (dirty_q == 32'h00000000) |-> s_report(`S_OK)) else $error("legacy flush alias not honoured");
  a_scsi_resid: assert property (s_decode and feat_q[`FEAT_SCSI] && (code == `T_SCSI_OUT)
    |=> (resid_q == len_q) && (sense_q == 8'h00)) else $error("packet residual wrong");
  a_used_order: assert property ($rose(used_q) |-> ($past(st_q, 2) == vbr_pkg::DONE_S)
    && (stat_q == res_q)) else $error("used before status");
endmodule

// ==== design/vbr_mem.sv ====
// single-port backing store with registered read data
`timescale 1ns/1ns
module vbr_mem #(
  parameter int AW = 9,
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= {DW{1'b0}};
    end
    else
    begin
      rdata_q <= mem[addr];
    end
  end
  assign rdata = rdata_q;
endmodule

// ==== design/vbr_pkg.sv ====
// types shared by the block request engine
package vbr_pkg;
  typedef enum logic [2:0] {IDLE_S, DECODE_S, XFER_S, ZERO_S, COMMIT_S, DONE_S, USED_S} vbr_state_type;
endpackage

// ==== design/vbr_regs.svh ====
// register offsets, field positions, codes and timing of the block request engine
// Functional notes
// - writeback field selects writethrough (0) or writeback (1)
// - read-only device fails every write with I/O error, storage untouched
// - unknown segment flag on discard or write-zeroes gives unsupported
// - discard with unmap set gives unsupported
// - discard may deallocate ranges, but need not
// - write-zeroes makes ranges read back zero, unmap or not
// - may-unmap field clear exactly when write-zeroes never deallocates
// - stable writes are committed before their completion is reported
// - flush completes only after earlier completed writes are committed
// - without flush offered, device may still commit before completion
// - legacy mode uses guest native byte order in the header
// - legacy type 5 behaves exactly as flush
// - barrier request waits for earlier ones and holds back later ones
// - packet command types 2 and 3 are one; command length from buffer
// - packet command writes up to 96 sense bytes, reports the count
// - residual is requested data length minus bytes moved
// - header is device-readable; transfer size from data buffer length
// - type codes: read 0, write 1, flush 4, discard 11, write-zeroes 13
// - status byte: 0 ok, 1 I/O error, 2 unsupported
// - sector unit and data unit are 512 bytes
`ifndef VBR_REGS_SVH
`define VBR_REGS_SVH
// ==========================================================
// register map (byte addresses)
`define OFF_FEAT 12'h000
`define OFF_WBACK 12'h004
`define OFF_MAYUNMAP 12'h008
`define OFF_TYPE 12'h00C
`define OFF_SEC_LO 12'h010
`define OFF_SEC_HI 12'h014
`define OFF_LEN 12'h018
`define OFF_NSEC 12'h01C
`define OFF_FLAGS 12'h020
`define OFF_CMDLEN 12'h024
`define OFF_DOORBELL 12'h028
`define OFF_STATUS 12'h02C
`define OFF_DATA 12'h030
`define OFF_SENSE 12'h034
`define OFF_RESID 12'h038
`define OFF_DIRTY 12'h03C
// ==========================================================
// feature / mode bits of the feature register, its reset value, and the status register bit positions
`define FEAT_RO 0
`define FEAT_FLUSH_OFF 1
`define FEAT_FLUSH_NEG 2
`define FEAT_WCE_NEG 3
`define FEAT_BARRIER 4
`define FEAT_SCSI 5
`define FEAT_LEGACY 6
`define FEAT_GUEST_BE 7
`define FEAT_RESET 8'h00
`define STAT_USED 8
`define STAT_BUSY 9
`define STAT_DATA 10
// ==========================================================
// request types and status codes
`define T_IN 32'h00000000
`define T_OUT 32'h00000001
`define T_SCSI 32'h00000002
`define T_SCSI_OUT 32'h00000003
`define T_FLUSH 32'h00000004
`define T_FLUSH_OUT 32'h00000005
`define T_DISCARD 32'h0000000B
`define T_WZEROES 32'h0000000D
`define BARRIER_BIT 31
`define S_OK 8'h00
`define S_IOERR 8'h01
`define S_UNSUPP 8'h02
// ==========================================================
// storage geometry and timing
`define CAP_SECTORS 65'h4
`define SECTOR_SHIFT 9
`define WORD_SHIFT 7
`define MEM_AW 9
`define CLK_PERIOD_NS 50
`define COMMIT_TIME_NS 1000
`define COMMIT_CYC ((`COMMIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== test/vbr_drv.sv ====
// apb master model standing in for the guest driver
`timescale 1ns/1ns
module vbr_drv (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hang
);
  // ==========================================
  // idle bus
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    hang = 1'b0;
  end
  // ==========================================
  // one transfer
  // request held unchanged until pready is sampled high; no latency assumed
  task automatic xact(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    err = pslverr;
    if (n >= 40)
      hang <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ==== test/virtual_block_request_engine_tb.sv ====
// self-checking bench for the block request engine
`timescale 1ns/1ns
`include "vbr_regs.svh"
module virtual_block_request_engine_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hang;
  int err_total;
  int checks;

  vbr_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  vbr_drv drv_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hang(hang));

  always #25 pclk = ~pclk;

  // ==========================================
  // helpers
  task automatic finish_test();
    $display("mismatches=%0d comparisons=%0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge pclk)
    if (hang === 1'b1)
    begin
      err_total++;
      finish_test();
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    drv_u.xact(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    drv_u.xact(1'b0, a, 32'h00000000, q, e);
    chk(q, exp);
  endtask

  task automatic start(input logic [31:0] t, input logic [31:0] lo, input logic [31:0] hi,
    input logic [31:0] len, input logic [31:0] flg);
    wr(`OFF_TYPE, t);
    wr(`OFF_SEC_LO, lo);
    wr(`OFF_SEC_HI, hi);
    wr(`OFF_LEN, len);
    wr(`OFF_NSEC, 32'h00000001);
    wr(`OFF_FLAGS, flg);
    wr(`OFF_DOORBELL, 32'h00000001);
  endtask

  // bounded poll of one status bit; a hang ends the run
  task automatic poll(input int b, output logic [31:0] s);
    logic e;
    int n;
    n = 0;
    s = 32'h00000000;
    while (s[b] !== 1'b1)
    begin
      drv_u.xact(1'b0, `OFF_STATUS, 32'h00000000, s, e);
      n++;
      if (n > 300)
      begin
        err_total++;
        finish_test();
      end
    end
  endtask

  // status byte is only trusted once the used flag shows
  task automatic done(input logic [7:0] exp);
    logic [31:0] s;
    poll(`STAT_USED, s);
    chk({24'h000000, s[7:0]}, {24'h000000, exp});
  endtask

  task automatic run(input logic [31:0] t, input logic [31:0] lo, input logic [31:0] hi,
    input logic [31:0] len, input logic [31:0] flg, input logic [7:0] exp);
    start(t, lo, hi, len, flg);
    done(exp);
  endtask

  task automatic move(input logic w, input logic [7:0] sec, input logic z);
    logic [31:0] s;
    logic [31:0] p;
    poll(`STAT_DATA, s);
    for (int i = 0; i < 128; i++)
    begin
      p = z ? 32'h00000000 : {8'hA5, sec, 16'(i)};
      if (w)
        wr(`OFF_DATA, p);
      else
        rdc(`OFF_DATA, p);
    end
  endtask

  task automatic wsec(input logic [7:0] sec);
    start(`T_OUT, {24'h000000, sec}, 32'h00000000, 32'h00000200, 32'h00000000);
    move(1'b1, sec, 1'b0);
    done(`S_OK);
  endtask

  task automatic rsec(input logic [7:0] sec, input logic z);
    start(`T_IN, {24'h000000, sec}, 32'h00000000, 32'h00000200, 32'h00000000);
    move(1'b0, sec, z);
    done(`S_OK);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rdc(`OFF_FEAT, 32'h00000000);
    rdc(`OFF_STATUS, 32'h00000000);
    rdc(`OFF_DIRTY, 32'h00000000);
    wr(`OFF_MAYUNMAP, 32'h00000001);
    rdc(`OFF_MAYUNMAP, 32'h00000000);
    wr(`OFF_WBACK, 32'h00000001);
    rdc(`OFF_WBACK, 32'h00000000);
    drv_u.xact(1'b0, 12'h040, 32'h00000000, q, e);
    chk(32'(e), 32'h00000001);
    drv_u.xact(1'b1, 12'h006, 32'h00000000, q, e);
    chk(32'(e), 32'h00000001);
  endtask

  task automatic t_data();
    wsec(8'h01);
    rdc(`OFF_DIRTY, 32'h00000000);
    rsec(8'h01, 1'b0);
    wsec(8'h03);
    run(`T_IN, 32'h3, 32'h0, 32'h00000400, 32'h0, `S_IOERR);
    run(`T_OUT, 32'h0, 32'h0, 32'h00000064, 32'h0, `S_IOERR);
    run(32'h00000007, 32'h0, 32'h0, 32'h0, 32'h0, `S_UNSUPP);
  endtask

  task automatic t_ro();
    wr(`OFF_FEAT, 32'h00000001);
    run(`T_OUT, 32'h1, 32'h0, 32'h00000200, 32'h0, `S_IOERR);
    run(`T_WZEROES, 32'h1, 32'h0, 32'h0, 32'h0, `S_IOERR);
    wr(`OFF_FEAT, 32'h00000000);
    rsec(8'h01, 1'b0);
  endtask

  task automatic t_flags();
    run(`T_DISCARD, 32'h1, 32'h0, 32'h0, 32'h00000001, `S_UNSUPP);
    run(`T_DISCARD, 32'h1, 32'h0, 32'h0, 32'h00000002, `S_UNSUPP);
    run(`T_WZEROES, 32'h1, 32'h0, 32'h0, 32'h80000000, `S_UNSUPP);
    run(`T_DISCARD, 32'h3, 32'h0, 32'h0, 32'h0, `S_OK);
    run(`T_WZEROES, 32'h1, 32'h0, 32'h0, 32'h00000001, `S_OK);
    rsec(8'h01, 1'b1);
  endtask

  task automatic t_cache();
    wr(`OFF_FEAT, 32'h0000000E);
    wr(`OFF_WBACK, 32'h00000001);
    rdc(`OFF_WBACK, 32'h00000001);
    wsec(8'h02);
    rdc(`OFF_DIRTY, 32'h00000001);
    run(`T_FLUSH, 32'h0, 32'h0, 32'h0, 32'h0, `S_OK);
    rdc(`OFF_DIRTY, 32'h00000000);
    wr(`OFF_WBACK, 32'h00000000);
    wsec(8'h02);
    rdc(`OFF_DIRTY, 32'h00000000);
    wr(`OFF_FEAT, 32'h00000006);
    wsec(8'h02);
    rdc(`OFF_DIRTY, 32'h00000001);
    run(`T_FLUSH_OUT, 32'h0, 32'h0, 32'h0, 32'h0, `S_UNSUPP);
    wr(`OFF_FEAT, 32'h00000046);
    run(`T_FLUSH_OUT, 32'h0, 32'h0, 32'h0, 32'h0, `S_OK);
    rdc(`OFF_DIRTY, 32'h00000000);
    wr(`OFF_FEAT, 32'h00000002);
    wsec(8'h02);
    rdc(`OFF_DIRTY, 32'h00000000);
  endtask

  task automatic t_legacy();
    wr(`OFF_FEAT, 32'h000000C0);
    run(32'h05000000, 32'h0, 32'h0, 32'h0, 32'h0, `S_OK);
    start(32'h00000000, 32'h0, 32'h02000000, 32'h00000200, 32'h0);
    move(1'b0, 8'h02, 1'b0);
    done(`S_OK);
    wr(`OFF_FEAT, 32'h00000010);
    run(32'h80000004, 32'h0, 32'h0, 32'h0, 32'h0, `S_OK);
    wr(`OFF_FEAT, 32'h00000000);
    run(32'h80000004, 32'h0, 32'h0, 32'h0, 32'h0, `S_UNSUPP);
  endtask

  task automatic t_packet();
    wr(`OFF_FEAT, 32'h00000020);
    wr(`OFF_CMDLEN, 32'h00000006);
    for (int t = 2; t < 4; t++)
    begin
      run(t, 32'h0, 32'h0, 32'h00000200, 32'h0, `S_UNSUPP);
      rdc(`OFF_SENSE, 32'h00000000);
      rdc(`OFF_RESID, 32'h00000200);
    end
    wr(`OFF_CMDLEN, 32'h00000000);
    run(`T_SCSI, 32'h0, 32'h0, 32'h0, 32'h0, `S_IOERR);
    wr(`OFF_FEAT, 32'h00000000);
    run(`T_SCSI_OUT, 32'h0, 32'h0, 32'h0, 32'h0, `S_UNSUPP);
  endtask

  // mid-run reset must bring features and status back to zero
  task automatic t_rst2();
    wr(`OFF_FEAT, 32'h0000003F);
    rdc(`OFF_FEAT, 32'h0000003F);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`OFF_FEAT, 32'h00000000);
    rdc(`OFF_STATUS, 32'h00000000);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_data();
    t_ro();
    t_flags();
    t_cache();
    t_legacy();
    t_packet();
    t_rst2();
    finish_test();
  end
endmodule
